// File: poe_seq_pkg.sv
// constants, codes and helpers for the port detect/classify sequencer
package poe_seq_pkg;
    localparam int NPORT        = 4;
    localparam int CLK_KHZ      = 125_000;
    localparam int POINT_MS     = 100;
    localparam int CYCLE_MAX_MS = 230;
    localparam int REPEAT_MS    = 320;
    localparam int CLASS_MS     = 15;
    localparam int START_MS     = 60;
    localparam int POINT_CYC    = POINT_MS * CLK_KHZ;
    localparam int CYCLE_MAX_CYC = CYCLE_MAX_MS * CLK_KHZ;
    localparam int REPEAT_CYC   = REPEAT_MS * CLK_KHZ;
    localparam int CLASS_CYC    = CLASS_MS * CLK_KHZ;
    localparam int START_CYC    = START_MS * CLK_KHZ;

    localparam logic [7:0] OFS_STATUS0 = 8'h0C;
    localparam logic [7:0] OFS_MODE    = 8'h12;
    localparam logic [7:0] OFS_ENABLE  = 8'h14;
    localparam logic [7:0] OFS_RESTART = 8'h18;
    localparam logic [7:0] OFS_POWER   = 8'h19;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam int DET_LSB = 0;
    localparam int CLS_LSB = 4;

    localparam logic [1:0] MODE_SHDN   = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_SEMI   = 2'h2;
    localparam logic [1:0] MODE_AUTO   = 2'h3;

    localparam logic [2:0] DET_UNKNOWN = 3'h0;
    localparam logic [2:0] DET_SHORT   = 3'h1;
    localparam logic [2:0] DET_CAP     = 3'h2;
    localparam logic [2:0] DET_RLOW    = 3'h3;
    localparam logic [2:0] DET_GOOD    = 3'h4;
    localparam logic [2:0] DET_RHIGH   = 3'h5;
    localparam logic [2:0] DET_OPEN    = 3'h6;
    localparam logic [2:0] CLS_OVER    = 3'h7;

    localparam logic [1:0] PROBE_OFF = 2'h0;
    localparam logic [1:0] PROBE_I1  = 2'h1;
    localparam logic [1:0] PROBE_I2  = 2'h2;
    localparam logic [1:0] PROBE_CLS = 2'h3;

    // second test current minus first, in microamps
    localparam int DI_UA = 160;
    localparam logic [15:0] DV_SHORT_MV = 16'(1000 * DI_UA / 1000);
    localparam logic [15:0] DV_MIN_MV   = 16'(17000 * DI_UA / 1000);
    localparam logic [15:0] DV_MAX_MV   = 16'(29000 * DI_UA / 1000);
    localparam logic [15:0] DV_OPEN_MV  = 16'(100000 * DI_UA / 1000);
    localparam logic [7:0] CLS1_MA = 8'h08;
    localparam logic [7:0] CLS2_MA = 8'h10;
    localparam logic [7:0] CLS3_MA = 8'h19;
    localparam logic [7:0] CLS4_MA = 8'h23;
    localparam logic [7:0] CLSX_MA = 8'h2D;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PT1, ST_PT2, ST_CLASS, ST_GAP, ST_POWERED
    } seq_state_t;

    // slope of the two points cancels diode and leakage offsets
    function automatic logic [2:0] det_code(input logic [15:0] v1,
                                            input logic [15:0] v2,
                                            input logic cap);
        logic [15:0] dv;
        dv = v2 - v1;
        if (v2 < v1 || dv < DV_SHORT_MV) det_code = DET_SHORT;
        else if (dv > DV_OPEN_MV) det_code = DET_OPEN;
        else if (dv < DV_MIN_MV) det_code = DET_RLOW;
        else if (dv > DV_MAX_MV) det_code = DET_RHIGH;
        else if (cap) det_code = DET_CAP;
        else det_code = DET_GOOD;
    endfunction

    function automatic logic [2:0] cls_code(input logic [7:0] ma);
        if (ma < CLS1_MA) cls_code = 3'h0;
        else if (ma < CLS2_MA) cls_code = 3'h1;
        else if (ma < CLS3_MA) cls_code = 3'h2;
        else if (ma < CLS4_MA) cls_code = 3'h3;
        else if (ma <= CLSX_MA) cls_code = 3'h4;
        else cls_code = CLS_OVER;
    endfunction
endpackage

// File: poe_seq.sv
// four-port signature detection, classification and power sequencer
`timescale 1ns/1ns
module poe_seq #(
    parameter int POINT_CYC     = poe_seq_pkg::POINT_CYC,
    parameter int CYCLE_MAX_CYC = poe_seq_pkg::CYCLE_MAX_CYC,
    parameter int REPEAT_CYC    = poe_seq_pkg::REPEAT_CYC,
    parameter int CLASS_CYC     = poe_seq_pkg::CLASS_CYC,
    parameter int START_CYC     = poe_seq_pkg::START_CYC
) (
    input  wire logic        clk,                   // 125 MHz
    input  wire logic        resetn,                // async reset
    input  wire logic        auto_strap,            // start mode strap
    input  wire logic        reg_wr,                // write strobe
    input  wire logic        reg_rd,                // read strobe
    input  wire logic [7:0]  reg_addr,              // register offset
    input  wire logic [7:0]  reg_wdata,             // write data
    output logic      [7:0]  reg_rdata,             // read data
    input  wire logic [63:0] port_volt,             // mV per port
    input  wire logic [3:0]  cap_high,              // load cap too big
    input  wire logic [31:0] class_ma,              // mA per port
    input  wire logic [3:0]  fault_off,             // timer fault kill
    output logic      [7:0]  probe_current_pin,     // probe select
    output logic      [31:0] port_status,           // status per port
    output logic      [3:0]  port_power,            // power enable
    output logic      [3:0]  start_timer_run,       // inrush timing
    output logic      [3:0]  overcurrent_timer_run, // steady timing
    output logic      [11:0] budget_class           // power budget
);
    localparam int NP = poe_seq_pkg::NPORT;
    localparam int DET_LO = poe_seq_pkg::DET_LSB;
    localparam int DET_HI = poe_seq_pkg::DET_LSB + 2;
    localparam int CLS_LO = poe_seq_pkg::CLS_LSB;
    localparam int CLS_HI = poe_seq_pkg::CLS_LSB + 2;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic [7:0] mode_r, mode_nxt;
    logic [3:0] det_en_r, det_en_nxt;
    logic [3:0] cls_en_r, cls_en_nxt;
    logic       init_r, init_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] rst_det, rst_cls, cmd_on, cmd_off;
    logic [1:0] sidx;

    assign rst_det = (reg_wr && reg_addr == poe_seq_pkg::OFS_RESTART)
                     ? reg_wdata[3:0] : 4'h0;
    assign rst_cls = (reg_wr && reg_addr == poe_seq_pkg::OFS_RESTART)
                     ? reg_wdata[7:4] : 4'h0;
    assign cmd_on  = (reg_wr && reg_addr == poe_seq_pkg::OFS_POWER)
                     ? reg_wdata[3:0] : 4'h0;
    assign cmd_off = (reg_wr && reg_addr == poe_seq_pkg::OFS_POWER)
                     ? reg_wdata[7:4] : 4'h0;
    assign sidx    = 2'(reg_addr - poe_seq_pkg::OFS_STATUS0);

    always_comb begin
        mode_nxt   = mode_r;
        det_en_nxt = det_en_r;
        cls_en_nxt = cls_en_r;
        init_nxt   = 1'b1;
        rdata_nxt  = 8'h00;
        // strap is caught on the first edge after release, not by reset
        if (!init_r) begin
            mode_nxt   = auto_strap ? {NP{poe_seq_pkg::MODE_AUTO}}
                                    : {NP{poe_seq_pkg::MODE_SHDN}};
            det_en_nxt = {NP{auto_strap}};
            cls_en_nxt = {NP{auto_strap}};
        end else if (reg_wr && reg_addr == poe_seq_pkg::OFS_MODE) begin
            mode_nxt = reg_wdata;
        end else if (reg_wr && reg_addr == poe_seq_pkg::OFS_ENABLE) begin
            det_en_nxt = reg_wdata[3:0];
            cls_en_nxt = reg_wdata[7:4];
        end
        for (int i = 0; i < NP; i++) begin
            // reset-time mode reads as shutdown; it must not wipe the strap load
            if (init_r && mode_r[2*i +: 2] == poe_seq_pkg::MODE_SHDN) begin
                det_en_nxt[i] = 1'b0;
                cls_en_nxt[i] = 1'b0;
            end
        end
        if (reg_rd && reg_addr >= poe_seq_pkg::OFS_STATUS0
            && reg_addr < poe_seq_pkg::OFS_STATUS0 + 8'h04) begin
            rdata_nxt = port_status[8*sidx +: 8];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r   <= 8'h00;
            det_en_r <= 4'h0;
            cls_en_r <= 4'h0;
            init_r   <= 1'b0;
            rdata_r  <= 8'h00;
        end else begin
            mode_r   <= mode_nxt;
            det_en_r <= det_en_nxt;
            cls_en_r <= cls_en_nxt;
            init_r   <= init_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    for (genvar i = 0; i < NP; i++) begin : g_port
        poe_seq_pkg::seq_state_t st_r, st_nxt;
        logic [31:0] cnt_r, cnt_nxt;
        logic [31:0] start_r, start_nxt;
        logic [15:0] v1_r, v1_nxt;
        logic        cap_r, cap_nxt;
        logic [7:0]  stat_r, stat_nxt;
        logic        pwr_r, pwr_nxt;
        logic [1:0]  probe_r, probe_nxt;
        logic [1:0]  mode;
        logic [15:0] volt;
        logic [2:0]  code;
        logic [2:0]  cls;
        logic        shdn, off_req, go_pwr, end_pt1, end_pt2, end_cls;

        assign mode    = mode_r[2*i +: 2];
        assign volt    = port_volt[16*i +: 16];
        assign shdn    = mode == poe_seq_pkg::MODE_SHDN;
        assign off_req = cmd_off[i] | fault_off[i] | shdn;
        assign end_pt1 = st_r == poe_seq_pkg::ST_PT1
                         && cnt_r == 32'(POINT_CYC - 1);
        assign end_pt2 = st_r == poe_seq_pkg::ST_PT2
                         && cnt_r == 32'(2 * POINT_CYC - 1);
        assign end_cls = st_r == poe_seq_pkg::ST_CLASS
                         && cnt_r == 32'(2 * POINT_CYC + CLASS_CYC - 1);
        assign code    = poe_seq_pkg::det_code(v1_r, volt, cap_r | cap_high[i]);
        assign cls     = poe_seq_pkg::cls_code(class_ma[8*i +: 8]);

        always_comb begin
            st_nxt    = st_r;
            cnt_nxt   = cnt_r + 32'h1;
            start_nxt = (pwr_r && start_r != 32'h0) ? start_r - 32'h1 : start_r;
            v1_nxt    = v1_r;
            cap_nxt   = cap_r | cap_high[i];
            stat_nxt  = stat_r;
            pwr_nxt   = pwr_r;
            go_pwr    = 1'b0;
            case (st_r)
                poe_seq_pkg::ST_IDLE: begin
                    cnt_nxt = 32'h0;
                    cap_nxt = 1'b0;
                    if ((mode == poe_seq_pkg::MODE_SEMI
                         || mode == poe_seq_pkg::MODE_AUTO) && det_en_r[i]) begin
                        st_nxt = poe_seq_pkg::ST_PT1;
                    end else if (mode == poe_seq_pkg::MODE_MANUAL) begin
                        if (rst_det[i] && det_en_r[i]) begin
                            st_nxt = poe_seq_pkg::ST_PT1;
                        end else if (rst_cls[i] && cls_en_r[i]) begin
                            st_nxt  = poe_seq_pkg::ST_CLASS;
                            cnt_nxt = 32'(2 * POINT_CYC);
                        end
                    end
                end
                poe_seq_pkg::ST_PT1: begin
                    if (end_pt1) begin
                        v1_nxt = volt;
                        st_nxt = poe_seq_pkg::ST_PT2;
                    end
                end
                poe_seq_pkg::ST_PT2: begin
                    if (end_pt2) begin
                        stat_nxt[DET_HI:DET_LO] = code;
                        if (mode == poe_seq_pkg::MODE_MANUAL) begin
                            st_nxt = poe_seq_pkg::ST_IDLE;
                        end else if (code != poe_seq_pkg::DET_GOOD) begin
                            st_nxt = poe_seq_pkg::ST_GAP;
                        end else if (cls_en_r[i]) begin
                            st_nxt = poe_seq_pkg::ST_CLASS;
                        end else if (mode == poe_seq_pkg::MODE_AUTO) begin
                            go_pwr = 1'b1;
                        end else begin
                            st_nxt = poe_seq_pkg::ST_GAP;
                        end
                    end
                end
                poe_seq_pkg::ST_CLASS: begin
                    if (end_cls) begin
                        stat_nxt[CLS_HI:CLS_LO] = cls;
                        if (mode == poe_seq_pkg::MODE_MANUAL) begin
                            st_nxt = poe_seq_pkg::ST_IDLE;
                        end else if (mode == poe_seq_pkg::MODE_AUTO) begin
                            go_pwr = 1'b1;
                        end else begin
                            st_nxt = poe_seq_pkg::ST_GAP;
                        end
                    end
                end
                poe_seq_pkg::ST_GAP: begin
                    // one idle cycle follows, so leave early to keep the period exact
                    if (cnt_r >= 32'(REPEAT_CYC - 2)) begin
                        st_nxt = poe_seq_pkg::ST_IDLE;
                    end
                end
                poe_seq_pkg::ST_POWERED: begin
                    cnt_nxt = 32'h0;
                end
                default: begin
                    st_nxt = poe_seq_pkg::ST_IDLE;
                end
            endcase
            // a disabled step is abandoned rather than finished
            if ((st_r == poe_seq_pkg::ST_PT1 || st_r == poe_seq_pkg::ST_PT2)
                && !det_en_r[i]) begin
                st_nxt = poe_seq_pkg::ST_IDLE;
            end
            if (st_r == poe_seq_pkg::ST_CLASS && !cls_en_r[i]) begin
                st_nxt = poe_seq_pkg::ST_IDLE;
            end
            if (cmd_on[i] && (mode == poe_seq_pkg::MODE_MANUAL
                              || mode == poe_seq_pkg::MODE_SEMI)) begin
                go_pwr = 1'b1;
            end
            if (off_req) begin
                pwr_nxt = 1'b0;
                if (st_r == poe_seq_pkg::ST_POWERED) begin
                    st_nxt = poe_seq_pkg::ST_IDLE;
                end
            end else if (go_pwr && !pwr_r) begin
                pwr_nxt   = 1'b1;
                st_nxt    = poe_seq_pkg::ST_POWERED;
                start_nxt = 32'(START_CYC);
            end
            if (shdn) begin
                st_nxt   = poe_seq_pkg::ST_IDLE;
                stat_nxt = poe_seq_pkg::STATUS_RST;
            end
            case (st_nxt)
                poe_seq_pkg::ST_PT1:   probe_nxt = poe_seq_pkg::PROBE_I1;
                poe_seq_pkg::ST_PT2:   probe_nxt = poe_seq_pkg::PROBE_I2;
                poe_seq_pkg::ST_CLASS: probe_nxt = poe_seq_pkg::PROBE_CLS;
                default:               probe_nxt = poe_seq_pkg::PROBE_OFF;
            endcase
        end

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                st_r    <= poe_seq_pkg::ST_IDLE;
                cnt_r   <= 32'h0;
                start_r <= 32'h0;
                v1_r    <= 16'h0;
                cap_r   <= 1'b0;
                stat_r  <= poe_seq_pkg::STATUS_RST;
                pwr_r   <= 1'b0;
                probe_r <= 2'h0;
            end else begin
                st_r    <= st_nxt;
                cnt_r   <= cnt_nxt;
                start_r <= start_nxt;
                v1_r    <= v1_nxt;
                cap_r   <= cap_nxt;
                stat_r  <= stat_nxt;
                pwr_r   <= pwr_nxt;
                probe_r <= probe_nxt;
            end
        end

        assign probe_current_pin[2*i +: 2] = probe_r;
        assign port_status[8*i +: 8]       = stat_r;
        assign port_power[i]               = pwr_r;
        // one limit threshold; only the running timer differs
        assign start_timer_run[i]       = pwr_r && start_r != 32'h0;
        assign overcurrent_timer_run[i] = pwr_r && start_r == 32'h0;
        assign budget_class[3*i +: 3]   = (stat_r[CLS_HI:CLS_LO] == 3'h4)
                                          ? 3'h0 : stat_r[CLS_HI:CLS_LO];

        property p_probe_first;
            st_r == poe_seq_pkg::ST_PT1 |-> probe_r == poe_seq_pkg::PROBE_I1;
        endproperty
        a_probe_first: assert property (p_probe_first)
            else $error("first point without first test current");

        property p_second_point;
            end_pt1 && det_en_r[i] && !off_req && !cmd_on[i]
            |=> st_r == poe_seq_pkg::ST_PT2 && probe_r == poe_seq_pkg::PROBE_I2;
        endproperty
        a_second_point: assert property (p_second_point)
            else $error("second point did not follow the first");

        property p_cycle_bound;
            st_r == poe_seq_pkg::ST_PT2 |-> cnt_r < 32'(CYCLE_MAX_CYC);
        endproperty
        a_cycle_bound: assert property (p_cycle_bound)
            else $error("detection cycle overran its limit");

        property p_good;
            end_pt2 && code == poe_seq_pkg::DET_GOOD && !shdn
            |=> stat_r[DET_HI:DET_LO] == poe_seq_pkg::DET_GOOD;
        endproperty
        a_good: assert property (p_good)
            else $error("good signature not posted");

        property p_cap;
            end_pt2 && (cap_r || cap_high[i])
            |=> stat_r[DET_HI:DET_LO] != poe_seq_pkg::DET_GOOD;
        endproperty
        a_cap: assert property (p_cap)
            else $error("good reported with excess capacitance");

        property p_no_det_powered;
            pwr_r |-> !(st_r inside {poe_seq_pkg::ST_PT1, poe_seq_pkg::ST_PT2});
        endproperty
        a_no_det_powered: assert property (p_no_det_powered)
            else $error("detection running on a powered port");

        property p_semi_gated;
            mode == poe_seq_pkg::MODE_SEMI && !pwr_r && !cmd_on[i]
            |=> !pwr_r;
        endproperty
        a_semi_gated: assert property (p_semi_gated)
            else $error("semiauto port powered without command");

        property p_auto_power;
            end_cls && mode == poe_seq_pkg::MODE_AUTO && cls_en_r[i] && !off_req
            |=> pwr_r && start_timer_run[i];
        endproperty
        a_auto_power: assert property (p_auto_power)
            else $error("auto port not powered after classification");

        property p_class_off;
            shdn || pwr_r || !cls_en_r[i] |=> st_r != poe_seq_pkg::ST_CLASS;
        endproperty
        a_class_off: assert property (p_class_off)
            else $error("classification while disabled");

        property p_shdn;
            init_r && shdn
            |=> stat_r == 8'h00 && !pwr_r && !det_en_r[i] && !cls_en_r[i];
        endproperty
        a_shdn: assert property (p_shdn)
            else $error("shutdown left state behind");
    end
endmodule

// File: pd_model.sv
// powered device model: signature resistor, load cap and class current per port
`timescale 1ns/1ns
module pd_model (
    input  wire logic        clk,               // system clock
    input  wire logic [7:0]  probe_current_pin, // probe select per port
    input  wire logic [31:0] res_ohm [4],       // signature resistance, ohm
    input  wire logic [7:0]  cls_ma [4],        // class current, mA
    input  wire logic [3:0]  cap_in,            // oversize load cap
    output logic      [63:0] port_volt,         // port voltage, mV
    output logic      [3:0]  cap_high,          // cap flag during detection probes
    output logic      [31:0] class_ma           // class current, mA
);
    logic [15:0] noise_r = 16'h0000;
    // unprobed port floats: a moving pattern, so stale values never match
    always_ff @(posedge clk) noise_r <= noise_r + 16'h3B5D;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            // 700 mV diode offset, only the slope tells the resistance
            case (probe_current_pin[2*i+:2])
                2'h1: port_volt[16*i+:16] = 16'(700 + 100 * res_ohm[i] / 1000);
                2'h2: port_volt[16*i+:16] = 16'(700 + 260 * res_ohm[i] / 1000);
                default: port_volt[16*i+:16] = noise_r ^ 16'(i);
            endcase
            cap_high[i] = cap_in[i] && (probe_current_pin[2*i+:2] inside {2'h1, 2'h2});
            class_ma[8*i+:8] = (probe_current_pin[2*i+:2] == 2'h3) ? cls_ma[i] : noise_r[7:0];
        end
    end
endmodule

// File: poe_port_detect_classify_sequencer_tb.sv
// self-checking testbench for the port detect/classify sequencer
`timescale 1ns/1ns
module poe_port_detect_classify_sequencer_tb;
    localparam int PT = 20, CM = 46, RP = 64, CL = 5, ST = 10;
    logic clk = 0, resetn = 0, auto_strap = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd;
    logic [3:0] fault_off = 4'h0, cap_in = 4'h0, cap_high;
    logic [31:0] res_ohm [4];
    logic [7:0] cls_ma [4];
    logic [63:0] port_volt;
    logic [31:0] class_ma, port_status;
    logic [7:0] reg_rdata, probe_current_pin;
    logic [3:0] port_power, start_timer_run, overcurrent_timer_run;
    logic [11:0] budget_class;
    int num_errors = 0, comparisons = 0, seed = 67;
    int corner [8] = '{500, 25000, 10000, 200000, 40000, 25000, 17000, 29000};
    int cls_tab [8] = '{2, 10, 18, 28, 40, 50, 0, 0};
    logic [2:0] c;

    poe_seq #(.POINT_CYC(PT), .CYCLE_MAX_CYC(CM), .REPEAT_CYC(RP), .CLASS_CYC(CL),
              .START_CYC(ST)) poe_seq_inst (.clk(clk), .resetn(resetn),
        .auto_strap(auto_strap), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_volt(port_volt),
        .cap_high(cap_high), .class_ma(class_ma), .fault_off(fault_off),
        .probe_current_pin(probe_current_pin), .port_status(port_status),
        .port_power(port_power), .start_timer_run(start_timer_run),
        .overcurrent_timer_run(overcurrent_timer_run), .budget_class(budget_class));
    pd_model pd_model_inst (.clk(clk), .probe_current_pin(probe_current_pin),
        .res_ohm(res_ohm), .cls_ma(cls_ma), .cap_in(cap_in), .port_volt(port_volt),
        .cap_high(cap_high), .class_ma(class_ma));

    always #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        cyc(1);
        reg_wr = 0;
    endtask
    task automatic rdreg(input logic [7:0] a);
        @(posedge clk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        cyc(1);
        reg_rd = 0;
        rd = reg_rdata;
    endtask
    function automatic logic [2:0] exp_det(input int r, input logic cp);
        if (r < 1000) return 3'h1;
        if (r > 100000) return 3'h6;
        if (r < 17000) return 3'h3;
        if (r > 29000) return 3'h5;
        return cp ? 3'h2 : 3'h4;
    endfunction
    function automatic logic [2:0] exp_cls(input int ma);
        if (ma < 8) return 3'h0;
        if (ma < 16) return 3'h1;
        if (ma < 25) return 3'h2;
        if (ma < 35) return 3'h3;
        return (ma <= 45) ? 3'h4 : 3'h7;
    endfunction

    initial begin
        for (int i = 0; i < 4; i++) {res_ohm[i], cls_ma[i]} = {32'd25000, 8'd28};
        repeat (16) @(posedge clk);
        #1 resetn = 1;
        cyc(2);
        check(port_status, 0, "status after reset");
        wr(8'h18, 8'h0F);
        cyc(2 * PT);
        check(probe_current_pin, 0, "probe in shutdown");
        wr(8'h12, 8'h55);
        wr(8'h14, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 4; i++)
                res_ohm[i] = k < 2 ? corner[4*k+i] : 100 * (10 + $unsigned($random(seed)) % 700);
            cap_in = k == 1 ? 4'h2 : (k > 1 ? 4'($random(seed)) : 4'h0);
            wr(8'h18, 8'h0F);
            cyc(2);
            check(probe_current_pin[1:0], 1, "first point");
            cyc(PT);
            check(probe_current_pin[1:0], 2, "second point");
            // host waits a full worst-case cycle before reading
            cyc(CM - PT - 2);
            check(probe_current_pin, 0, "back to idle");
            for (int i = 0; i < 4; i++) begin
                rdreg(8'h0C + 8'(i));
                check(rd[2:0], exp_det(res_ohm[i], cap_in[i]), "detect code");
            end
        end
        rdreg(8'h30);
        check(rd, 0, "unmapped read");
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++)
                cls_ma[i] = (k == 1 && i > 1) ? $unsigned($random(seed)) % 46 : cls_tab[4*k+i];
            wr(8'h18, 8'hF0);
            cyc(CL + 4);
            for (int i = 0; i < 4; i++) begin
                rdreg(8'h0C + 8'(i));
                c = exp_cls(cls_ma[i]);
                check(rd[6:4], c, "class code");
                if (c != 3'h7) check(budget_class[3*i+:3], c == 3'h4 ? 3'h0 : c, "budget");
            end
        end
        wr(8'h19, 8'h01);
        cyc(2);
        check({port_power[0], start_timer_run[0]}, 2'b11, "manual power on");
        cyc(ST + 2);
        check({start_timer_run[0], overcurrent_timer_run[0]}, 2'b01, "timer handover");
        wr(8'h18, 8'h11);
        cyc(3);
        check(probe_current_pin[1:0], 0, "no probing while powered");
        wr(8'h19, 8'h10);
        cyc(2);
        check(port_power, 0, "manual power off");
        for (int i = 0; i < 4; i++) {res_ohm[i], cls_ma[i]} = {32'd25000, 8'(cls_tab[i+1])};
        cap_in = 4'h0;
        wr(8'h12, 8'hAA);
        cyc(2 * RP + 10);
        check(port_power, 0, "semiauto never powers");
        for (int i = 0; i < 4; i++) begin
            rdreg(8'h0C + 8'(i));
            check(rd, {1'b0, exp_cls(cls_tab[i+1]), 4'h4}, "semiauto status");
        end
        res_ohm[0] = 10000;
        cyc(2 * RP);
        rdreg(8'h0C);
        check(rd[2:0], 3'h3, "semiauto repeats");
        res_ohm[0] = 25000;
        wr(8'h12, 8'hFF);
        cyc(2 * RP);
        check(port_power, 4'hF, "auto powers any class");
        check(budget_class[11:9], 0, "class 4 budget");
        fault_off = 4'h1;
        cyc(1);
        fault_off = 4'h0;
        cyc(1);
        check(port_power[0], 0, "fault removes power");
        wr(8'h12, 8'h00);
        cyc(2);
        check(port_status, 0, "shutdown clears status");
        check(port_power, 0, "shutdown clears power");
        resetn = 0;
        auto_strap = 1;
        cyc(3);
        resetn = 1;
        cyc(2 * RP);
        check(port_power, 4'hF, "strap high starts auto");
        final_report;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule
